// ---- src/sp_baud.sv ----
// Bit-rate generator: timer 1 in 8-bit auto-reload, the 16x tick for the
// asynchronous modes. Assumes mcycle_i pulses once per machine cycle.
`timescale 1ns/10ps
module sp_baud
   import sp_pkg::*;
(
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // Configuration
   input  sp_mode_t        mode_i,
   input  wire logic       baud_doubler_i,
   input  wire logic [3:0] t1_mode_i,
   input  wire logic       t1_run_i,
   input  wire logic [7:0] t1_reload_i,
   input  wire logic       mcycle_i,
   // Sixteen ticks per bit time
   output logic            tick16_o
);

   typedef struct packed {
      logic [7:0] count;
      logic       half;
      logic [1:0] div;
      logic       tick;
   } sp_baud_t;

   sp_baud_t s;
   sp_baud_t next_s;
   logic     ovf;

   always_comb
   begin
      next_s = s;
      ovf    = 1'b0;
      // Only the auto-reload mode is modelled; one step per machine cycle
      if (t1_run_i && t1_mode_i == T1_AUTO && mcycle_i)
      begin
         if (s.count == T1_TOP)
         begin
            next_s.count = t1_reload_i;
            ovf          = 1'b1;
         end
         else
            next_s.count = s.count + 8'h01;
      end
      next_s.tick = 1'b0;
      if (mode_i == SP_MODE2)
      begin
         // 16 ticks per bit: osc/4 or osc/2
         if (s.div == (baud_doubler_i ? M2_DIV32 : M2_DIV64))
         begin
            next_s.div  = 2'h0;
            next_s.tick = 1'b1;
         end
         else
            next_s.div = s.div + 2'h1;
      end
      else if (ovf)
      begin
         // Overflow rate times 2^doubler over 32
         next_s.half = ~s.half;
         next_s.tick = baud_doubler_i | s.half;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         s <= '0;
      else
         s <= next_s;
   end

   assign tick16_o = s.tick;

endmodule : sp_baud

// ---- src/sp_pkg.sv ----
// Serial port package: register map, field layout, machine-cycle timing,
// mode and sequencer enumerations, shared helper functions.
// Assumes the core clock is the oscillator itself (40 MHz).
package sp_pkg;

   // Machine cycle: six states of two phases each
   localparam int unsigned OSC_PER_MCYCLE = 12;
   localparam logic [3:0]  PH_S1P1 = 4'h0;
   localparam logic [3:0]  PH_S3P1 = 4'h4;
   localparam logic [3:0]  PH_S5P2 = 4'h9;
   localparam logic [3:0]  PH_S6P1 = 4'hA;
   localparam logic [3:0]  PH_S6P2 = 4'hB;
   localparam logic [3:0]  PH_LAST = 4'(OSC_PER_MCYCLE - 1);

   // Register byte addresses
   localparam logic [7:0] ADR_BUF  = 8'h00;
   localparam logic [7:0] ADR_CTL  = 8'h04;
   localparam logic [7:0] ADR_PWR  = 8'h08;
   localparam logic [7:0] ADR_TIMER_MODE_REG = 8'h0C;
   localparam logic [7:0] ADR_RLD  = 8'h10;
   localparam logic [7:0] ADR_TRUN = 8'h14;
   localparam logic [7:0] REG_RST  = 8'h00;

   // Control register fields
   localparam int CTL_RI      = 0;
   localparam int CTL_TI      = 1;
   localparam int CTL_RB8     = 2;
   localparam int CTL_TB8     = 3;
   localparam int CTL_REN     = 4;
   localparam int CTL_SM2     = 5;
   localparam int CTL_MODE_LO = 6;
   localparam int CTL_MODE_HI = 7;
   localparam int PWR_BAUD_DOUBLER    = 7;
   localparam int TRUN_BIT    = 0;
   localparam int TIMER_MODE_REG_T1_LO  = 4;
   localparam int TIMER_MODE_REG_T1_HI  = 7;

   // Shift register seeds and bit-time sampling points
   localparam logic [7:0] RX0_SEED   = 8'hFE;
   localparam logic [8:0] RX1_SEED   = 9'h1FF;
   localparam logic [8:0] TX_MARKER  = 9'h100;
   localparam logic [7:0] TX_ENDPAT  = 8'h01;
   localparam logic [3:0] SAMP_A     = 4'h7;
   localparam logic [3:0] SAMP_B     = 4'h8;
   localparam logic [3:0] SAMP_C     = 4'h9;
   localparam logic [3:0] CNT16_LAST = 4'hF;

   // Timer 1 auto-reload and fixed-rate dividers
   localparam logic [3:0] T1_AUTO    = 4'h2;
   localparam logic [7:0] T1_TOP     = 8'hFF;
   localparam logic [1:0] M2_DIV64   = 2'h3;
   localparam logic [1:0] M2_DIV32   = 2'h1;

   typedef enum logic [1:0] {SP_MODE0, SP_MODE1, SP_MODE2, SP_MODE3}
      sp_mode_t;
   typedef enum logic [2:0] {TX_IDLE, TX_REQ, TX_WAIT, TX_SEND, TX_LAST}
      sp_tx_t;
   typedef enum logic [1:0] {RX_IDLE, RX_ARMED, RX_BUSY, RX_LAST}
      sp_rx_t;

   function automatic logic majority3(input logic [2:0] v);
      majority3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
   endfunction : majority3

   function automatic logic [7:0] rev8(input logic [7:0] v);
      for (int i = 0; i < 8; i++)
      begin
         rev8[i] = v[7 - i];
      end
   endfunction : rev8

endpackage : sp_pkg

// ---- src/sp_serial_port.sv ----
// Serial port top: Wishbone register slave, machine-cycle sequencer,
// synchronous shift mode 0 and asynchronous 10-bit mode 1.
// Assumes a classic Wishbone master and external pins on rxd/txd.
//
// Functional notes
// - Mode 0 bit rate is oscillator over 12.
// - Mode 2 rate osc/64, or osc/32 doubled.
// - Modes 1,3 rate: timer overflow, doubler, /32.
// - Auto-reload timer overflows every 256-reload steps.
// - Tabulated reload settings give the listed rates.
// - Mode 0: data on rxd, clock on txd.
// - Mode 0 write: marker loaded, send one cycle later.
// - Sending drives data and shift clock S3-S5 low.
// - Each S6P2 while sending, shift right, zero fill.
// - Marker-only left: last shift, done at S1P1.
// - Receive when enabled and done clear; seed 11111110.
// - Clock toggles S3P1/S6P1; shift left at S6P2.
// - Zero reaches left: final shift, load, flag.
// - Mode 1 frame start, eight data, stop.
// - Mode 1 start after next divide-by-16 rollover.
// - Start bit, then data, then first shift.
// - Marker left alone: last shift, then done flag.
// - Sample input 16x; falling edge resets counter.
// - Majority of samples seven, eight and nine.
// - Start bit not zero: abandon and search again.
// - Final shift; load only if flag, filter allow.
// - Buffer write feeds transmit, read gives receive.
// - Interrupt request is OR of both done flags.
`timescale 1ns/10ps
module sp_serial_port
   import sp_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Serial pins
   input  wire logic        rxd_i,
   output logic             rxd_o,
   output logic             rxd_oe_o,
   output logic             txd_o,
   // Interrupt request
   output logic             serial_irq_o
);

   typedef struct packed {
      logic [3:0]  phase;
      sp_tx_t      tx_st;
      logic [8:0]  tx_shift;
      logic        tx_data_en;
      logic [3:0]  tx_cnt16;
      sp_rx_t      rx_st;
      logic [8:0]  rx_shift;
      logic        rx_first;
      logic [3:0]  rx_cnt16;
      logic [2:0]  rx_samp;
      logic        rx_bit0;
      logic        rx_prev;
      logic [7:0]  serial_buffer;
      logic [7:0]  serial_control_reg;
      logic [7:0]  power_control_reg;
      logic [7:0]  timer_mode_reg;
      logic [7:0]  timer1_reload_byte;
      logic [7:0]  timer_run_reg;
      logic        ack;
      logic [31:0] dat;
   } sp_state_t;

   sp_state_t s;
   sp_state_t next_s;

   sp_mode_t   mode;
   logic       mode0;
   logic       rxd_sync;
   logic       tick16;
   logic       mcycle;
   logic       access;
   logic       wr;
   logic       shift_clk;
   logic       tx_roll;
   logic       rx_maj;
   logic [8:0] rx_next;
   logic [7:0] rd_byte;

   assign mode   = sp_mode_t'(s.serial_control_reg[CTL_MODE_HI:CTL_MODE_LO]);
   assign mode0  = (mode == SP_MODE0);
   assign mcycle = (s.phase == PH_LAST);
   assign access = wb_cyc_i & wb_stb_i & ~s.ack;
   assign wr     = access & wb_we_i & wb_sel_i[0];

   sp_sync u_sync (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .pin_i   (rxd_i),
      .level_o (rxd_sync)
   );

   sp_baud u_baud (
      .clk_i          (clk_i),
      .rst_i          (rst_i),
      .mode_i         (mode),
      .baud_doubler_i (s.power_control_reg[PWR_BAUD_DOUBLER]),
      .t1_mode_i      (s.timer_mode_reg[TIMER_MODE_REG_T1_HI:TIMER_MODE_REG_T1_LO]),
      .t1_run_i       (s.timer_run_reg[TRUN_BIT]),
      .t1_reload_i    (s.timer1_reload_byte),
      .mcycle_i       (mcycle),
      .tick16_o       (tick16)
   );

   // Read mux; unmapped addresses read as zero
   always_comb
   begin
      unique case (wb_adr_i)
         ADR_BUF:  rd_byte = s.serial_buffer;
         ADR_CTL:  rd_byte = s.serial_control_reg;
         ADR_PWR:  rd_byte = s.power_control_reg;
         ADR_TIMER_MODE_REG: rd_byte = s.timer_mode_reg;
         ADR_RLD:  rd_byte = s.timer1_reload_byte;
         ADR_TRUN: rd_byte = s.timer_run_reg;
         default:  rd_byte = REG_RST;
      endcase
   end

   always_comb
   begin
      next_s = s;
      tx_roll = 1'b0;
      rx_maj  = majority3(s.rx_samp);
      rx_next = {s.rx_shift[7:0], rx_maj};

      // Machine cycle: twelve clocks, one per phase
      next_s.phase = mcycle ? PH_S1P1 : s.phase + 4'h1;

      // Bus slave: one wait state, ack for exactly one cycle
      next_s.ack = access;
      if (access)
         next_s.dat = {24'h000000, rd_byte};
      if (wr)
      begin
         unique case (wb_adr_i)
            ADR_BUF:
            begin
               // Ninth position carries the marker/stop bit
               next_s.tx_shift   = TX_MARKER | {1'b0, wb_dat_i[7:0]};
               next_s.tx_st      = TX_REQ;
               next_s.tx_data_en = 1'b0;
            end
            ADR_CTL:  next_s.serial_control_reg = wb_dat_i[7:0];
            ADR_PWR:  next_s.power_control_reg  = wb_dat_i[7:0];
            ADR_TIMER_MODE_REG: next_s.timer_mode_reg     = wb_dat_i[7:0];
            ADR_RLD:  next_s.timer1_reload_byte = wb_dat_i[7:0];
            ADR_TRUN: next_s.timer_run_reg      = wb_dat_i[7:0];
            default:  next_s.dat                = s.dat;
         endcase
      end

      // Divide-by-16 counter that paces transmit bit times
      if (tick16)
      begin
         next_s.tx_cnt16 = s.tx_cnt16 + 4'h1;
         tx_roll = (s.tx_cnt16 == CNT16_LAST);
      end

      // Transmit sequencer
      if (!(wr && wb_adr_i == ADR_BUF))
      begin
         unique case (s.tx_st)
            TX_IDLE: next_s.tx_st = TX_IDLE;
            TX_REQ:
            begin
               if (mode0 ? (s.phase == PH_S6P2) : tx_roll)
                  next_s.tx_st = TX_WAIT;
            end
            TX_WAIT:
            begin
               // Mode 0: one whole machine cycle before sending
               if (mode0 ? (s.phase == PH_S6P2) : (s.phase == PH_S1P1))
                  next_s.tx_st = TX_SEND;
            end
            TX_SEND:
            begin
               if (mode0 && s.phase == PH_S6P2)
               begin
                  next_s.tx_shift = {1'b0, s.tx_shift[8:1]};
                  if (s.tx_shift[8:1] == TX_ENDPAT)
                     next_s.tx_st = TX_LAST;
               end
               else if (!mode0 && tx_roll)
               begin
                  if (!s.tx_data_en)
                     next_s.tx_data_en = 1'b1;
                  else
                  begin
                     next_s.tx_shift = {1'b0, s.tx_shift[8:1]};
                     if (s.tx_shift[8:1] == TX_ENDPAT)
                        next_s.tx_st = TX_LAST;
                  end
               end
            end
            TX_LAST:
            begin
               if (mode0 ? (s.phase == PH_S1P1) : tx_roll)
               begin
                  next_s.tx_st = TX_IDLE;
                  next_s.serial_control_reg[CTL_TI] = 1'b1;
               end
            end
         endcase
      end

      // Receive sequencer
      unique case (s.rx_st)
         RX_IDLE:
         begin
            if (mode0)
            begin
               if (s.serial_control_reg[CTL_REN] &&
                   !s.serial_control_reg[CTL_RI])
                  next_s.rx_st = RX_ARMED;
            end
            else if (tick16)
            begin
               // Falling edge restarts the bit-time counter
               next_s.rx_prev = rxd_sync;
               if (s.rx_prev && !rxd_sync)
               begin
                  next_s.rx_st    = RX_BUSY;
                  next_s.rx_cnt16 = 4'h0;
                  next_s.rx_shift = RX1_SEED;
                  next_s.rx_first = 1'b1;
               end
            end
         end
         RX_ARMED:
         begin
            if (s.phase == PH_S6P2)
            begin
               next_s.rx_shift = {1'b1, RX0_SEED};
               next_s.rx_st    = RX_BUSY;
            end
         end
         RX_BUSY:
         begin
            if (mode0)
            begin
               if (s.phase == PH_S5P2)
                  next_s.rx_bit0 = rxd_sync;
               if (s.phase == PH_S6P2)
               begin
                  next_s.rx_shift = {1'b1, s.rx_shift[6:0], s.rx_bit0};
                  if (!s.rx_shift[7])
                  begin
                     // Final shift loads the buffer, LSB first
                     next_s.serial_buffer =
                        rev8({s.rx_shift[6:0], s.rx_bit0});
                     next_s.rx_st = RX_LAST;
                  end
               end
            end
            else if (tick16)
            begin
               next_s.rx_prev  = rxd_sync;
               next_s.rx_cnt16 = s.rx_cnt16 + 4'h1;
               if (s.rx_cnt16 == SAMP_A || s.rx_cnt16 == SAMP_B ||
                   s.rx_cnt16 == SAMP_C)
                  next_s.rx_samp = {s.rx_samp[1:0], rxd_sync};
               if (s.rx_cnt16 == CNT16_LAST)
               begin
                  next_s.rx_first = 1'b0;
                  if (s.rx_first && rx_maj)
                     next_s.rx_st = RX_IDLE;
                  else if (!s.rx_shift[8])
                  begin
                     // Start bit at the left end: frame complete
                     next_s.rx_st = RX_IDLE;
                     if (!s.serial_control_reg[CTL_RI] &&
                         (!s.serial_control_reg[CTL_SM2] || rx_maj))
                     begin
                        next_s.serial_buffer = rev8(rx_next[8:1]);
                        next_s.serial_control_reg[CTL_RB8] = rx_maj;
                        next_s.serial_control_reg[CTL_RI]  = 1'b1;
                     end
                  end
                  else
                     next_s.rx_shift = rx_next;
               end
            end
         end
         RX_LAST:
         begin
            if (s.phase == PH_S1P1)
            begin
               next_s.rx_st = RX_IDLE;
               next_s.serial_control_reg[CTL_RI] = 1'b1;
            end
         end
      endcase

      // A mode change abandons a reception in progress
      if (wr && wb_adr_i == ADR_CTL &&
          wb_dat_i[CTL_MODE_HI:CTL_MODE_LO] !=
          s.serial_control_reg[CTL_MODE_HI:CTL_MODE_LO])
         next_s.rx_st = RX_IDLE;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         s            <= '0;
         s.tx_st      <= TX_IDLE;
         s.rx_st      <= RX_IDLE;
         s.rx_prev    <= 1'b1;
      end
      else
         s <= next_s;
   end

   // Shift clock low from S3P1 until S6P1
   assign shift_clk = (s.phase < PH_S3P1) || (s.phase >= PH_S6P1);

   always_comb
   begin
      rxd_o    = 1'b1;
      rxd_oe_o = 1'b0;
      txd_o    = 1'b1;
      if (mode0)
      begin
         if (s.tx_st == TX_SEND || s.tx_st == TX_LAST)
         begin
            rxd_o    = s.tx_shift[0];
            rxd_oe_o = 1'b1;
            txd_o    = shift_clk;
         end
         else if (s.rx_st == RX_BUSY || s.rx_st == RX_LAST)
            txd_o = shift_clk;
      end
      else if (s.tx_st == TX_SEND || s.tx_st == TX_LAST)
         txd_o = s.tx_data_en ? s.tx_shift[0] : 1'b0;
   end

   assign wb_dat_o     = s.dat;
   assign wb_ack_o     = s.ack;
   assign serial_irq_o = s.serial_control_reg[CTL_RI] |
                         s.serial_control_reg[CTL_TI];

endmodule : sp_serial_port

// ---- src/sp_sync.sv ----
// Two-flop synchroniser for the serial input pin.
// Assumes the pin is asynchronous to clk_i.
`timescale 1ns/10ps
module sp_sync
   import sp_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // Pin and synchronised level
   input  wire logic pin_i,
   output logic      level_o
);

   typedef struct packed {
      logic meta;
      logic level;
   } sp_sync_t;

   sp_sync_t s;
   sp_sync_t next_s;

   always_comb
   begin
      next_s.meta  = pin_i;
      next_s.level = s.meta;
   end

   // Idle line is high, so reset to 1 to avoid a false start edge
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         s <= '1;
      else
         s <= next_s;
   end

   assign level_o = s.level;

endmodule : sp_sync

// ---- testbench/sp_far_end.sv ----
// Far side: an external shift register for mode 0 and a remote
// asynchronous transceiver for mode 1; resolves the shared data wire.
`timescale 1ns/10ps
module sp_far_end
#(
   parameter int BIT_CLKS = 192
)
(
   // Clock
   input  wire logic clk_i,
   // Device pins
   input  wire logic txd_i,
   input  wire logic dev_rxd_i,
   input  wire logic dev_oe_i,
   input  wire logic uart_on_i,
   // Resolved data wire
   output logic      line_o
);
   logic [7:0] shreg  = 8'hFF;
   logic [7:0] cap    = 8'h00;
   logic       lvl    = 1'b1;
   logic [9:0] frame;
   logic [9:0] seen;

   // Pull-up: the wire idles high when nobody drives it
   assign line_o = dev_oe_i ? dev_rxd_i : (shreg[0] & lvl);

   // Move on the rising clock, after the device sampled at S5P2
   always @(posedge txd_i)
   begin
      if (dev_oe_i)
         cap <= {dev_rxd_i, cap[7:1]};
      else if (!uart_on_i)
         shreg <= {1'b1, shreg[7:1]};
   end

   always
   begin
      @(negedge txd_i iff uart_on_i);
      repeat (BIT_CLKS / 2) @(posedge clk_i);
      for (int i = 0; i < 10; i++)
      begin
         seen[i] = txd_i;
         repeat (BIT_CLKS) @(posedge clk_i);
      end
   end

   task automatic send(input logic [7:0] d, input logic stop);
      frame = {stop, d, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         @(posedge clk_i);
         lvl <= frame[i];
         repeat (BIT_CLKS - 1) @(posedge clk_i);
      end
      @(posedge clk_i);
      lvl <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk_i);
   endtask : send

   task automatic glitch(input int n);
      @(posedge clk_i);
      lvl <= 1'b0;
      repeat (n) @(posedge clk_i);
      lvl <= 1'b1;
      repeat (BIT_CLKS) @(posedge clk_i);
   endtask : glitch
endmodule : sp_far_end

// ---- testbench/sp_serial_port_asserts.sv ----
// Checker for the serial port top: bus handshake, mode 0 shift timing,
// mode 0 start and flag timing, mode 1 transmit start timing.
// Assumes it sees only the top module's ports, bound below.
`timescale 1ns/10ps
module sp_serial_port_asserts
   import sp_pkg::*;
(
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // Wishbone slave
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // Serial pins and request
   input wire logic        rxd_i,
   input wire logic        rxd_o,
   input wire logic        rxd_oe_o,
   input wire logic        txd_o,
   input wire logic        serial_irq_o
);
   logic       take;
   logic       buf_wr;
   logic       ctl_wr;
   logic       rx0_go;
   logic [1:0] mode_q;

   assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign buf_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_BUF;
   assign ctl_wr = take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTL;
   // Flags are not visible here, so only writes that clear both count
   assign rx0_go = ctl_wr && wb_dat_i[7:4] == 4'h1 && wb_dat_i[1:0] == 2'h0;

   // Mode as software last wrote it
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         mode_q <= 2'h0;
      else if (ctl_wr)
         mode_q <= wb_dat_i[7:6];
   end

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   AST_ACK_ONE:
      assert property (take |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack is not one pulse after the request");
   AST_UPPER_ZERO:
      assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bytes not zero");
   AST_UNMAPPED:
      assert property (take && !wb_we_i && wb_adr_i == 8'h18
                       |=> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   AST_TX0_SEND:
      assert property (buf_wr && mode_q == 2'h0 |-> ##[12:26] $rose(rxd_oe_o))
      else $error("mode 0 send did not start in time");
   AST_TX0_DONE:
      assert property (buf_wr && mode_q == 2'h0
                       |-> ##[96:136] $rose(serial_irq_o))
      else $error("mode 0 transmit flag not set in time");
   AST_CLK_LOW:
      assert property (mode_q == 2'h0 && $fell(txd_o)
                       |-> !txd_o [*6] ##1 txd_o)
      else $error("shift clock low time wrong");
   AST_DATA_EDGE:
      assert property (rxd_oe_o && $past(rxd_oe_o) && $changed(rxd_o)
                       |-> txd_o)
      else $error("mode 0 data moved while clock low");
   AST_RX0_START:
      assert property (rx0_go |-> ##[1:32] $fell(txd_o))
      else $error("mode 0 receive clock did not start");
   AST_RX0_DONE:
      assert property (rx0_go |-> ##[96:136] $rose(serial_irq_o))
      else $error("mode 0 receive flag not set in time");
   AST_IRQ_CLEAR:
      assert property (ctl_wr && wb_dat_i[1:0] == 2'h0 |=> !serial_irq_o)
      else $error("request stays after both flags cleared");
   AST_TX1_START:
      assert property (buf_wr && mode_q == 2'h1 |-> ##[1:215] $fell(txd_o))
      else $error("mode 1 start bit late");
endmodule : sp_serial_port_asserts

bind sp_serial_port sp_serial_port_asserts i_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .rxd_i(rxd_i), .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o),
   .serial_irq_o(serial_irq_o));

// ---- testbench/sp_serial_port_bench.sv ----
// Bench for the serial port: registers, mode 0 both ways, mode 1 frames,
// false start and refused frames. Far side is sp_far_end.
`timescale 1ns/10ps
module sp_serial_port_bench
   import sp_pkg::*;
;
   logic        clk     = 1'b0;
   logic        rst     = 1'b1;
   logic        cyc     = 1'b0;
   logic        stb     = 1'b0;
   logic        we      = 1'b0;
   logic [7:0]  adr     = 8'h00;
   logic [3:0]  sel     = 4'h0;
   logic [31:0] wdat    = 32'h0;
   logic        uart_on = 1'b0;
   logic [31:0] rdat;
   logic [31:0] rd;
   logic        ack;
   logic        txd;
   logic        dout;
   logic        oe;
   logic        irq;
   logic        line;
   logic [7:0]  regs [6] = '{ADR_BUF, ADR_CTL, ADR_PWR, ADR_TIMER_MODE_REG, ADR_RLD,
                             ADR_TRUN};
   int          miscompares = 0;
   int          checked     = 0;
   time         t0;

   always #12.5 clk = ~clk;

   sp_serial_port i_dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rxd_i(line),
      .rxd_o(dout), .rxd_oe_o(oe), .txd_o(txd), .serial_irq_o(irq));
   sp_far_end #(.BIT_CLKS(192)) i_far (.clk_i(clk), .txd_i(txd),
      .dev_rxd_i(dout), .dev_oe_i(oe), .uart_on_i(uart_on), .line_o(line));

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h, want %h", $time, got, exp);
      end
   endtask : check

   // Ack and read data are taken at the rising edge that sees ack high,
   // and the request is released at that same edge
   task automatic bus(input logic w, input logic [3:0] s,
                      input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      sel  <= s;
      adr  <= a;
      wdat <= d;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 100);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      check({31'h0, n < 100}, 32'h1);
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, 4'h1, a, d);
   endtask : wr

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, 4'h1, a, 32'h0);
      check(rd, exp);
   endtask : rdchk

   task automatic wait_irq;
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 4000)
      begin
         @(negedge clk);
         n++;
      end
      check({31'h0, irq}, 32'h1);
   endtask : wait_irq

   task automatic give_verdict;
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : give_verdict

   initial
   begin
      repeat (40000) @(posedge clk);
      miscompares++;
      give_verdict;
   end

   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      foreach (regs[i]) rdchk(regs[i], 32'h0);
      bus(1'b1, 4'h0, ADR_CTL, 32'h10);
      rdchk(ADR_CTL, 32'h0);
      wr(8'h18, 32'hFF);
      rdchk(8'h18, 32'h0);
      wr(ADR_PWR, 32'h80);
      wr(ADR_TIMER_MODE_REG, 32'h20);
      wr(ADR_RLD, 32'hFF);
      wr(ADR_TRUN, 32'h01);
      rdchk(ADR_PWR, 32'h80);
      rdchk(ADR_TIMER_MODE_REG, 32'h20);
      rdchk(ADR_RLD, 32'hFF);
      $display("test registers done");
      wr(ADR_BUF, 32'hA5);
      wait_irq;
      check({24'h0, i_far.cap}, 32'hA5);
      rdchk(ADR_CTL, 32'h02);
      wr(ADR_CTL, 32'h00);
      check({31'h0, irq}, 32'h0);
      $display("test mode 0 transmit done");
      i_far.shreg = 8'h3C;
      wr(ADR_CTL, 32'h10);
      wait_irq;
      rdchk(ADR_BUF, 32'h3C);
      rdchk(ADR_CTL, 32'h11);
      wr(ADR_CTL, 32'h00);
      $display("test mode 0 receive done");
      // Timer 1 climbs from zero before its first overflow
      repeat (3072) @(posedge clk);
      uart_on <= 1'b1;
      wr(ADR_CTL, 32'h40);
      wr(ADR_BUF, 32'h96);
      wait_irq;
      repeat (192) @(posedge clk);
      check({22'h0, i_far.seen}, {22'h0, 1'b1, 8'h96, 1'b0});
      rdchk(ADR_CTL, 32'h42);
      $display("test mode 1 transmit done");
      wr(ADR_CTL, 32'h50);
      i_far.send(8'h5A, 1'b1);
      wait_irq;
      rdchk(ADR_BUF, 32'h5A);
      rdchk(ADR_CTL, 32'h55);
      wr(ADR_CTL, 32'h50);
      i_far.glitch(48);
      i_far.send(8'hC3, 1'b1);
      wait_irq;
      rdchk(ADR_BUF, 32'hC3);
      $display("test mode 1 receive done");
      i_far.send(8'h11, 1'b1);
      rdchk(ADR_BUF, 32'hC3);
      wr(ADR_CTL, 32'h70);
      i_far.send(8'h22, 1'b0);
      rdchk(ADR_CTL, 32'h70);
      i_far.send(8'h33, 1'b1);
      wait_irq;
      rdchk(ADR_BUF, 32'h33);
      rdchk(ADR_CTL, 32'h75);
      $display("test refused frames done");
      // Doubled mode 2: 32 clocks a bit, so a frame ends well inside 400
      wr(ADR_CTL, 32'h80);
      t0 = $time;
      wr(ADR_BUF, 32'h0F);
      wait_irq;
      check({31'h0, $time - t0 > 7500 && $time - t0 < 10000}, 32'h1);
      $display("test mode 2 rate done");
      give_verdict;
   end
endmodule : sp_serial_port_bench
